/* File: rtl/mrf_frame_checker.sv */
// rtu slave framing: apb registers, gap timing, crc check and response sender
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module mrf_frame_checker #(
  parameter logic [15:0] BIT_DIV_RESET = 16'(mrf_pkg::BIT_DIV_RESET),
  parameter int          BUF_BYTES     = 64
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rs485_rx,
  output logic             rs485_tx,
  output logic             rs485_oe
);
  localparam int IW = $clog2(BUF_BYTES) + 1;
  localparam logic [IW-1:0] MIN_LEN = IW'(mrf_pkg::MIN_FRAME);

  typedef enum logic [1:0] {
    T_IDLE  = 2'b00,
    T_GAP   = 2'b01,
    T_LOAD  = 2'b10,
    T_SHIFT = 2'b11
  } mrf_send_state_type;

  typedef struct packed {
    logic [1:0]                  rx_sync;
    logic                        pready;
    logic                        pslverr;
    logic [31:0]                 prdata;
    logic                        enable;
    logic                        seven;
    mrf_pkg::mrf_parity_type     parity;
    logic [7:0]                  my_addr;
    logic [15:0]                 bit_div;
    logic [15:0]                 half_cnt;
    logic [11:0]                 gap;
    logic [BUF_BYTES-1:0][7:0]   rx_buf;
    logic [IW-1:0]               rx_cnt;
    logic [15:0]                 rx_crc;
    logic                        rx_cerr;
    logic                        rx_ovf;
    logic                        rx_closed;
    logic                        done;
    logic                        crc_err;
    logic                        par_err;
    logic                        len_err;
    logic                        bcast;
    logic                        cmd_bad;
    logic [IW-1:0]               res_len;
    logic [IW-1:0]               rd_idx;
    logic [BUF_BYTES-1:0][7:0]   tx_buf;
    logic [IW-1:0]               tx_len;
    logic [IW-1:0]               tx_idx;
    logic [15:0]                 tx_crc;
    mrf_send_state_type          tx_state;
    logic                        tx_start;
    logic [7:0]                  tx_byte;
    logic                        refused;
    logic                        oe;
  } mrf_regs_type;

  mrf_regs_type r;
  mrf_regs_type n;
  logic         rx_valid;
  logic [7:0]   rx_byte;
  logic         rx_err;
  logic         rx_busy;
  logic         tx_done;
  logic         half_tick;
  logic         line_idle;
  logic         setup;
  logic         wr;
  logic         rd;
  logic         go;
  logic         eof;
  logic         addr_ok;
  logic [11:0]  nbits;
  logic [11:0]  t15;
  logic [11:0]  t35;
  logic [31:0]  status;

  always_comb begin
    n          = r;
    go         = 1'b0;
    n.rx_sync  = {r.rx_sync[0], rs485_rx};
    n.tx_start = 1'b0;
    nbits      = r.seven ? mrf_pkg::CHAR_BITS_7 : mrf_pkg::CHAR_BITS_8;
    t15        = nbits * mrf_pkg::GAP_SHORT_HALVES;
    t35        = nbits * mrf_pkg::GAP_LONG_HALVES;
    // half-bit enable keeps the gap figures exact at 1.5 and 3.5 characters
    half_tick  = (r.half_cnt == 16'h0000);
    n.half_cnt = half_tick ? ({1'b0, r.bit_div[15:1]} - 16'h0001) : (r.half_cnt - 16'h0001);
    line_idle  = r.rx_sync[1] && !rx_busy && !r.oe;
    if (!line_idle) begin
      n.gap = 12'h000;
    end else if (half_tick && (r.gap != 12'hfff)) begin
      n.gap = r.gap + 12'h001;
    end
    status = 32'h0000_0000;
    status[mrf_pkg::ST_DONE_BIT]     = r.done;
    status[mrf_pkg::ST_CRC_BIT]      = r.crc_err;
    status[mrf_pkg::ST_PAR_BIT]      = r.par_err;
    status[mrf_pkg::ST_LEN_BIT]      = r.len_err;
    status[mrf_pkg::ST_BCAST_BIT]    = r.bcast;
    status[mrf_pkg::ST_CMD_BIT]      = r.cmd_bad;
    status[mrf_pkg::ST_TXBUSY_BIT]   = (r.tx_state != T_IDLE);
    status[mrf_pkg::ST_REFUSED_BIT]  = r.refused;
    status[mrf_pkg::ST_RXLEN_LSB +: IW] = r.res_len;
    status[mrf_pkg::ST_TXLEN_LSB +: IW] = r.tx_len;

    // apb: zero wait states, read data and error latched in the setup cycle
    setup     = psel && !penable;
    wr        = psel && penable && r.pready && pwrite;
    rd        = psel && penable && r.pready && !pwrite;
    n.pready  = setup;
    n.pslverr = 1'b0;
    n.prdata  = 32'h0000_0000;
    if (setup) begin
      case (paddr)
        mrf_pkg::OFF_CTRL: begin
          n.prdata[mrf_pkg::CTRL_EN_BIT]       = r.enable;
          n.prdata[mrf_pkg::CTRL_SEVEN_BIT]    = r.seven;
          n.prdata[mrf_pkg::CTRL_PAR_LSB +: 2] = r.parity;
        end
        mrf_pkg::OFF_ADDR:    n.prdata[7:0]  = r.my_addr;
        mrf_pkg::OFF_BAUD:    n.prdata[15:0] = r.bit_div;
        mrf_pkg::OFF_STATUS:  n.prdata       = status;
        mrf_pkg::OFF_RX_DATA: begin
          if (r.rd_idx < r.res_len) begin
            n.prdata[7:0] = r.rx_buf[r.rd_idx[IW-2:0]];
          end
        end
        mrf_pkg::OFF_TX_DATA: n.prdata = 32'h0000_0000;
        default:              n.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      case (paddr)
        mrf_pkg::OFF_CTRL: begin
          n.enable = pwdata[mrf_pkg::CTRL_EN_BIT];
          n.seven  = pwdata[mrf_pkg::CTRL_SEVEN_BIT];
          n.parity = mrf_pkg::mrf_parity_type'(pwdata[mrf_pkg::CTRL_PAR_LSB +: 2]);
          if (pwdata[mrf_pkg::CTRL_PAR_LSB +: 2] == 2'b11) begin
            n.parity = mrf_pkg::PAR_NONE;
          end
          go = pwdata[mrf_pkg::CTRL_GO_BIT];
          if (pwdata[mrf_pkg::CTRL_CLR_BIT] && (r.tx_state == T_IDLE)) begin
            n.tx_len = '0;
          end
        end
        mrf_pkg::OFF_ADDR: n.my_addr = pwdata[7:0];
        mrf_pkg::OFF_BAUD: n.bit_div = pwdata[15:0];
        mrf_pkg::OFF_STATUS: begin
          n.done    = r.done & ~pwdata[mrf_pkg::ST_DONE_BIT];
          n.refused = r.refused & ~pwdata[mrf_pkg::ST_REFUSED_BIT];
        end
        mrf_pkg::OFF_TX_DATA: begin
          // bytes go out in write order, so software loads word msb first
          if ((r.tx_state == T_IDLE) && (r.tx_len < BUF_BYTES)) begin
            n.tx_buf[r.tx_len[IW-2:0]] = pwdata[7:0];
            n.tx_len                   = r.tx_len + IW'(1);
          end
        end
        default: n.tx_len = r.tx_len;
      endcase
    end
    if (rd && (paddr == mrf_pkg::OFF_RX_DATA) && (r.rd_idx < r.res_len)) begin
      n.rd_idx = r.rd_idx + IW'(1);
    end

    // receive framing; the buffer is shared, so read a frame before the next one starts
    eof     = (r.rx_cnt != '0) && (r.gap >= t35) && !rx_valid;
    addr_ok = ((r.rx_buf[0] == r.my_addr) || (r.rx_buf[0] == mrf_pkg::ADDR_BCAST)) &&
              (r.rx_buf[0] <= mrf_pkg::ADDR_LAST);
    if (rx_valid) begin
      if ((r.rx_cnt == '0) || r.rx_closed) begin
        n.rx_buf[0] = rx_byte;
        n.rx_cnt    = IW'(1);
        n.rx_crc    = mrf_pkg::crc_step(mrf_pkg::CRC_INIT, rx_byte);
        n.rx_cerr   = rx_err;
        n.rx_ovf    = 1'b0;
        n.rx_closed = 1'b0;
      end else if (r.rx_cnt < BUF_BYTES) begin
        n.rx_buf[r.rx_cnt[IW-2:0]] = rx_byte;
        n.rx_cnt  = r.rx_cnt + IW'(1);
        n.rx_crc  = mrf_pkg::crc_step(r.rx_crc, rx_byte);
        n.rx_cerr = r.rx_cerr | rx_err;
      end else begin
        n.rx_ovf = 1'b1;
      end
    end else if (eof) begin
      n.rx_cnt    = '0;
      n.rx_closed = 1'b0;
      if (addr_ok) begin
        n.done    = 1'b1;
        // crc over body plus its own two bytes leaves zero when they match
        n.crc_err = (r.rx_crc != 16'h0000);
        n.par_err = r.rx_cerr;
        n.len_err = (r.rx_cnt < MIN_LEN) || r.rx_cnt[0] || r.rx_ovf;
        n.bcast   = (r.rx_buf[0] == mrf_pkg::ADDR_BCAST);
        n.cmd_bad = (r.rx_buf[1] != mrf_pkg::CMD_READ) &&
                    (r.rx_buf[1] != mrf_pkg::CMD_WRITE);
        n.res_len = r.rx_cnt;
        n.rd_idx  = '0;
      end
    end else if ((r.rx_cnt != '0) && (r.gap >= t15)) begin
      n.rx_closed = 1'b1;
    end

    // response sender
    if (go && (r.tx_state != T_IDLE)) begin
      n.refused = 1'b1;
    end
    case (r.tx_state)
      T_IDLE: begin
        if (go) begin
          if (r.bcast || (r.tx_len == '0) || !r.enable) begin
            n.refused = 1'b1;
          end else begin
            n.tx_idx   = '0;
            n.tx_crc   = mrf_pkg::CRC_INIT;
            n.tx_state = T_GAP;
          end
        end
      end
      T_GAP: begin
        if (r.gap >= t35) begin
          n.oe       = 1'b1;
          n.tx_state = T_LOAD;
        end
      end
      T_LOAD: begin
        n.tx_start = 1'b1;
        n.tx_idx   = r.tx_idx + IW'(1);
        n.tx_state = T_SHIFT;
        if (r.tx_idx < r.tx_len) begin
          n.tx_byte = r.tx_buf[r.tx_idx[IW-2:0]];
          n.tx_crc  = mrf_pkg::crc_step(r.tx_crc, r.tx_buf[r.tx_idx[IW-2:0]]);
        end else if (r.tx_idx == r.tx_len) begin
          n.tx_byte = r.tx_crc[7:0];
        end else begin
          n.tx_byte = r.tx_crc[15:8];
        end
      end
      T_SHIFT: begin
        if (tx_done) begin
          if (r.tx_idx == (r.tx_len + IW'(2))) begin
            n.oe       = 1'b0;
            n.tx_state = T_IDLE;
          end else begin
            n.tx_state = T_LOAD;
          end
        end
      end
      default: n.tx_state = T_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r         <= '0;
      r.rx_sync <= 2'b11;
      r.enable  <= mrf_pkg::CTRL_EN_RESET;
      r.seven   <= mrf_pkg::CTRL_SEVEN_RESET;
      r.parity  <= mrf_pkg::CTRL_PAR_RESET;
      r.my_addr <= mrf_pkg::ADDR_RESET;
      r.bit_div <= BIT_DIV_RESET;
    end else begin
      r <= n;
    end
  end

  mrf_char_rx u_rx (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (r.enable && !r.oe),
    .line_in  (r.rx_sync[1]),
    .bit_div  (r.bit_div),
    .seven    (r.seven),
    .parity   (r.parity),
    .valid    (rx_valid),
    .data     (rx_byte),
    .char_err (rx_err),
    .busy     (rx_busy)
  );

  mrf_char_tx u_tx (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (r.tx_start),
    .data     (r.tx_byte),
    .bit_div  (r.bit_div),
    .seven    (r.seven),
    .parity   (r.parity),
    .line_out (rs485_tx),
    .done     (tx_done)
  );

  assign prdata   = r.prdata;
  assign pready   = r.pready;
  assign pslverr  = r.pslverr;
  assign rs485_oe = r.oe;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  crc_preset_a: assert property (
    rx_valid && (r.rx_cnt == '0) |=>
      r.rx_crc == mrf_pkg::crc_step(16'hffff, $past(rx_byte)))
    else $error("crc not preset at frame start");
  gap_restart_a: assert property (
    rx_valid && r.rx_closed |=> (r.rx_cnt == IW'(1)) && !r.rx_closed)
    else $error("late byte did not restart frame");
  frame_end_a: assert property (
    eof |=> (r.rx_cnt == '0))
    else $error("frame not closed after long gap");
  addr_drop_a: assert property (
    eof && !addr_ok && !r.done |=> !r.done)
    else $error("foreign frame reported");
  parity_flag_a: assert property (
    rx_valid && rx_err && (r.rx_cnt != '0) && !r.rx_closed && (r.rx_cnt < BUF_BYTES)
      |=> r.rx_cerr)
    else $error("bad character not flagged");
  bcast_quiet_a: assert property (
    go && r.bcast && (r.tx_state == T_IDLE) |=> r.refused && (r.tx_state == T_IDLE) ##1 !r.oe)
    else $error("reply started after broadcast");
  idle_before_tx_a: assert property (
    $rose(r.oe) |-> $past(r.gap) >= $past(t35))
    else $error("driver on before idle gap");
  crc_low_first_a: assert property (
    (r.tx_state == T_LOAD) && (r.tx_idx == r.tx_len) |=>
      (r.tx_byte == $past(r.tx_crc[7:0])) && r.tx_start)
    else $error("crc low byte not sent first");
  frame_length_a: assert property (
    $fell(r.oe) |-> $past(r.tx_idx) == ($past(r.tx_len) + IW'(2)))
    else $error("crc bytes missing from reply");
endmodule
`default_nettype wire

/* File: rtl/mrf_pkg.sv */
// shared constants, types and helper functions of the rtu frame checker
package mrf_pkg;
  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned BAUD_RESET_BPS = 9600;
  localparam int unsigned BIT_DIV_RESET  = (CLK_HZ + BAUD_RESET_BPS / 2) / BAUD_RESET_BPS;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_ADDR    = 8'h04;
  localparam logic [7:0] OFF_BAUD    = 8'h08;
  localparam logic [7:0] OFF_STATUS  = 8'h0c;
  localparam logic [7:0] OFF_RX_DATA = 8'h10;
  localparam logic [7:0] OFF_TX_DATA = 8'h14;

  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_SEVEN_BIT  = 1;
  localparam int CTRL_PAR_LSB    = 2;
  localparam int CTRL_GO_BIT     = 4;
  localparam int CTRL_CLR_BIT    = 5;
  localparam int ST_DONE_BIT     = 0;
  localparam int ST_CRC_BIT      = 1;
  localparam int ST_PAR_BIT      = 2;
  localparam int ST_LEN_BIT      = 3;
  localparam int ST_BCAST_BIT    = 4;
  localparam int ST_CMD_BIT      = 5;
  localparam int ST_TXBUSY_BIT   = 6;
  localparam int ST_REFUSED_BIT  = 7;
  localparam int ST_RXLEN_LSB    = 8;
  localparam int ST_TXLEN_LSB    = 16;

  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_EVEN = 2'b01,
    PAR_ODD  = 2'b10
  } mrf_parity_type;

  localparam logic           CTRL_EN_RESET    = 1'b0;
  localparam logic           CTRL_SEVEN_RESET = 1'b0;
  localparam mrf_parity_type CTRL_PAR_RESET   = PAR_EVEN;
  localparam logic [7:0]     ADDR_RESET       = 8'h01;

  localparam logic [7:0]  ADDR_BCAST       = 8'h00;
  localparam logic [7:0]  ADDR_LAST        = 8'hf7;
  localparam logic [7:0]  CMD_READ         = 8'h03;
  localparam logic [7:0]  CMD_WRITE        = 8'h06;
  localparam logic [15:0] CRC_INIT         = 16'hffff;
  localparam logic [15:0] CRC_POLY         = 16'ha001;
  localparam logic [11:0] CHAR_BITS_8      = 12'h00b;
  localparam logic [11:0] CHAR_BITS_7      = 12'h00a;
  localparam logic [11:0] GAP_SHORT_HALVES = 12'h003;
  localparam logic [11:0] GAP_LONG_HALVES  = 12'h007;
  localparam int          MIN_FRAME        = 4;

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      if (c[0])
        c = (c >> 1) ^ CRC_POLY;
      else
        c = c >> 1;
    end
    return c;
  endfunction

  function automatic logic parity_of(input logic [7:0] data, input logic seven,
                                     input mrf_parity_type mode);
    logic ones;
    ones = seven ? ^data[6:0] : ^data;
    return (mode == PAR_ODD) ? ~ones : ones;
  endfunction
endpackage

/* File: rtl/mrf_char_rx.sv */
// serial character receiver with parity and stop check
`timescale 1ns/100ps
`default_nettype none
module mrf_char_rx (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    enable,
  input  wire logic                    line_in,
  input  wire logic [15:0]             bit_div,
  input  wire logic                    seven,
  input  wire mrf_pkg::mrf_parity_type parity,
  output logic                         valid,
  output logic [7:0]                   data,
  output logic                         char_err,
  output logic                         busy
);
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100
  } mrf_rx_state_type;
  typedef struct packed {
    mrf_rx_state_type state;
    logic [15:0]      cnt;
    logic [2:0]       idx;
    logic [7:0]       sh;
    logic             perr;
    logic             valid;
    logic             err;
  } mrf_rx_regs_type;
  mrf_rx_regs_type r;
  mrf_rx_regs_type n;
  logic            tick;

  always_comb begin
    n       = r;
    n.valid = 1'b0;
    tick    = (r.cnt == 16'h0000);
    n.cnt   = tick ? (bit_div - 16'h0001) : (r.cnt - 16'h0001);
    case (r.state)
      RX_IDLE: begin
        if (enable && !line_in) begin
          n.state = RX_START;
          n.cnt   = {1'b0, bit_div[15:1]};
          n.sh    = 8'h00;
          n.perr  = 1'b0;
        end
      end
      RX_START: begin
        if (tick) begin
          n.state = line_in ? RX_IDLE : RX_DATA;
          n.idx   = 3'h0;
        end
      end
      RX_DATA: begin
        if (tick) begin
          n.sh[r.idx] = line_in;
          n.idx       = r.idx + 3'h1;
          if (r.idx == (seven ? 3'h6 : 3'h7)) begin
            n.state = (parity == mrf_pkg::PAR_NONE) ? RX_STOP : RX_PAR;
          end
        end
      end
      RX_PAR: begin
        if (tick) begin
          n.perr  = (line_in != mrf_pkg::parity_of(r.sh, seven, parity));
          n.state = RX_STOP;
        end
      end
      RX_STOP: begin
        if (tick) begin
          n.valid = 1'b1;
          n.err   = r.perr | !line_in;
          n.state = RX_IDLE;
        end
      end
      default: n.state = RX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign valid    = r.valid;
  assign data     = r.sh;
  assign char_err = r.err;
  assign busy     = (r.state != RX_IDLE);
endmodule
`default_nettype wire

/* File: rtl/mrf_char_tx.sv */
// serial character transmitter with optional parity bit
`timescale 1ns/100ps
`default_nettype none
module mrf_char_tx (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    start,
  input  wire logic [7:0]              data,
  input  wire logic [15:0]             bit_div,
  input  wire logic                    seven,
  input  wire mrf_pkg::mrf_parity_type parity,
  output logic                         line_out,
  output logic                         done
);
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_PAR   = 3'b011,
    TX_STOP  = 3'b100
  } mrf_tx_state_type;
  typedef struct packed {
    mrf_tx_state_type state;
    logic [15:0]      cnt;
    logic [2:0]       idx;
    logic [7:0]       sh;
    logic             stop2;
    logic             line;
    logic             done;
  } mrf_tx_regs_type;
  mrf_tx_regs_type r;
  mrf_tx_regs_type n;
  logic            tick;

  always_comb begin
    n      = r;
    n.done = 1'b0;
    tick   = (r.cnt == 16'h0000);
    n.cnt  = tick ? (bit_div - 16'h0001) : (r.cnt - 16'h0001);
    case (r.state)
      TX_IDLE: begin
        n.line = 1'b1;
        if (start) begin
          n.sh    = data;
          n.line  = 1'b0;
          n.cnt   = bit_div - 16'h0001;
          n.state = TX_START;
        end
      end
      TX_START: begin
        if (tick) begin
          n.idx   = 3'h0;
          n.line  = r.sh[0];
          n.state = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tick) begin
          n.idx  = r.idx + 3'h1;
          n.line = r.sh[r.idx + 3'h1];
          if (r.idx == (seven ? 3'h6 : 3'h7)) begin
            n.stop2 = (parity == mrf_pkg::PAR_NONE);
            n.line  = (parity == mrf_pkg::PAR_NONE) ? 1'b1 :
                      mrf_pkg::parity_of(r.sh, seven, parity);
            n.state = (parity == mrf_pkg::PAR_NONE) ? TX_STOP : TX_PAR;
          end
        end
      end
      TX_PAR: begin
        if (tick) begin
          n.line  = 1'b1;
          n.state = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tick) begin
          n.stop2 = 1'b0;
          if (!r.stop2) begin
            n.done  = 1'b1;
            n.state = TX_IDLE;
          end
        end
      end
      default: n.state = TX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r      <= '0;
      r.line <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign line_out = r.line;
  assign done     = r.done;
endmodule
`default_nettype wire

/* File: sim/mrf_master_model.sv */
// rtu master model: sends characters, captures reply characters
`timescale 1ns/100ps
`default_nettype none
module mrf_master_model (
  input  wire logic pclk,
  input  wire logic line_in,
  output logic      line_out
);
  int         bit_cyc = 8;
  logic [1:0] par_mode = 2'h1;
  logic [7:0] rb;
  logic [7:0] got_q[$];
  initial line_out = 1'h1;
  task automatic send_byte(input logic [7:0] b);
    logic [10:0] f;
    // no parity: the parity slot becomes the second stop
    f = {1'h1, (par_mode == 2'h0) | (^b ^ (par_mode == 2'h2)), b, 1'h0};
    for (int i = 0; i < 11; i++) begin
      line_out <= f[i];
      repeat (bit_cyc) @(posedge pclk);
    end
  endtask
  always begin
    @(negedge line_in);
    repeat (bit_cyc / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge pclk);
      rb[i] = line_in;
    end
    repeat (bit_cyc * 2) @(posedge pclk);
    got_q.push_back(rb);
  end
endmodule
`default_nettype wire

/* File: sim/mrf_frame_checker_tb_top.sv */
// self-checking bench of the rtu frame checker
`timescale 1ns/100ps
`default_nettype none
module mrf_frame_checker_tb_top;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} mrf_row_type;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, rx, tx, oe, er;
  int          err_total = 0, n_compared = 0;
  logic [7:0]  rep[8] = '{8'h02, 8'h06, 8'h00, 8'h04, 8'h13, 8'h88, 8'hc5, 8'h6e};
  mrf_row_type rows[8] = '{
    '{1'h0, 8'h00, 32'h0000_0000, 32'h0000_0004, 1'h0},
    '{1'h0, 8'h04, 32'h0000_0000, 32'h0000_0001, 1'h0},
    '{1'h0, 8'h08, 32'h0000_0000, 32'h0000_0008, 1'h0},
    '{1'h0, 8'h0c, 32'h0000_0000, 32'h0000_0000, 1'h0},
    '{1'h0, 8'h18, 32'h0000_0000, 32'h0000_0000, 1'h1},
    '{1'h1, 8'h00, 32'h0000_0005, 32'h0000_0000, 1'h0},
    '{1'h0, 8'h00, 32'h0000_0000, 32'h0000_0005, 1'h0},
    '{1'h0, 8'h14, 32'h0000_0000, 32'h0000_0000, 1'h0}};
  always #2 pclk = ~pclk;
  mrf_frame_checker #(.BIT_DIV_RESET(16'h0008)) uut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rs485_rx(rx), .rs485_tx(tx),
    .rs485_oe(oe));
  mrf_master_model mst (.pclk(pclk), .line_in(tx), .line_out(rx));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic frame(input logic [7:0] q[$], input int gap);
    foreach (q[i]) mst.send_byte(q[i]);
    repeat (gap) @(posedge pclk);
  endtask
  task automatic status(input logic [31:0] exp);
    apb(1'h0, 8'h0c, 32'h0000_0000);
    chk(rd, exp);
    apb(1'h1, 8'h0c, 32'h0000_0081);
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].x);
      chk({31'h0, er}, {31'h0, rows[i].e});
    end
    // sample frame with its known crc
    frame('{8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02, 8'h85, 8'hca}, 400);
    apb(1'h0, 8'h10, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'h0, 8'h10, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    status(32'h0000_0801);
    frame('{8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02, 8'h85, 8'hcb}, 400);
    status(32'h0000_0803);
    mst.par_mode = 2'h2;
    frame('{8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02, 8'h85, 8'hca}, 400);
    mst.par_mode = 2'h1;
    status(32'h0000_0805);
    // partial frame, then a gap between 1.5 and 3.5 characters
    frame('{8'h01, 8'h03}, 220);
    frame('{8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02, 8'h85, 8'hca}, 400);
    status(32'h0000_0801);
    for (int i = 0; i < 6; i++) apb(1'h1, 8'h14, {24'h0, rep[i]});
    // broadcast with a foreign crc: still accepted and flagged, reply refused
    frame('{8'h00, 8'h06, 8'h00, 8'h04, 8'h13, 8'h88, 8'hc5, 8'h6e}, 400);
    apb(1'h1, 8'h00, 32'h0000_0015);
    status(32'h0006_0893);
    // parity code 3 is kept as none; the master then sends two stop bits
    apb(1'h1, 8'h00, 32'h0000_000d);
    apb(1'h0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    mst.par_mode = 2'h0;
    frame('{8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02, 8'h85, 8'hca}, 400);
    mst.par_mode = 2'h1;
    status(32'h0006_0801);
    apb(1'h1, 8'h00, 32'h0000_0005);
    frame('{8'hf8, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02, 8'h85, 8'hca}, 400);
    status(32'h0006_0800);
    apb(1'h1, 8'h00, 32'h0000_0015);
    for (int n = 0; n < 8000 && mst.got_q.size() < 8; n++) @(posedge pclk);
    chk(mst.got_q.size(), 32'h0000_0008);
    foreach (mst.got_q[i]) chk({24'h0, mst.got_q[i]}, {24'h0, rep[i]});
    repeat (20) @(posedge pclk);
    chk({31'h0, oe}, 32'h0000_0000);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    print_verdict();
  end
endmodule
`default_nettype wire
